/* lmt_drive.sv */
// Top of the LCD multiplex drive timing: clock select, frame divider, sync and output drive.
`timescale 1ns/10ps
module lmt_drive
  import lmt_pkg::*;
#(
  parameter int OSC_HALF_CYC = LMT_OSC_HALF_CYC
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST_B,
  // Clock source strap and two-way clock pin.
  input wire logic OSC_STRAP,
  input wire logic CLK_I,
  output logic CLK_O,
  output logic CLK_OE_B,
  // Open-drain cascade sync pin.
  input wire logic SYNC_I,
  output logic SYNC_O,
  output logic SYNC_OE_B,
  // Mode-set command from the command decoder.
  input wire logic MODE_SET_STB,
  input wire logic [1:0] MODE_SEL,
  input wire logic BIAS_THIRD,
  // Display memory column write.
  input wire logic RAM_WR_STB,
  input wire logic [5:0] RAM_WR_COL,
  input wire logic [3:0] RAM_WR_DATA,
  // Drive level codes and frame marker.
  output logic [7:0] BACKPLANE_DRIVE_OUTPUTS,
  output logic [119:0] ELEMENT_DRIVE_OUTPUTS,
  output logic FRAME_RATE
);

  localparam int OW = $clog2(OSC_HALF_CYC + 1);
  localparam logic [OW-1:0] OSC_LAST = OW'(OSC_HALF_CYC - 1);

  typedef struct packed {
    logic [2:0] strap_cnt;
    logic strap_done;
    logic ext_sel;
    logic [OW-1:0] osc_cnt;
    logic clk_o;
    logic clk_prev;
    logic [4:0] tick_cnt;
    logic [4:0] sub_cnt;
    logic [1:0] row;
    logic pol;
    logic running;
    lmt_mode_type mode;
    logic bias_third;
    lmt_mode_type mode_pend;
    logic bias_pend;
    logic [1:0] load_cnt;
    logic [LMT_COLS-1:0] disp;
    logic [7:0] bp;
    logic [119:0] seg;
    logic frame;
    logic sync_oe_b;
    logic sync_prev;
    logic clk_oe_b;
  } lmt_state_type;

  lmt_state_type st_r;
  lmt_state_type st_nxt;

  logic [2:0] pins_s;
  logic [LMT_COLS-1:0] ram_rd;

  // ----------------------------------------
  // Pin synchronisers and display memory
  // ----------------------------------------

  // Strap, external clock and sync pin cross into the reference clock.
  lmt_sync3 #(.W(3)) u_sync (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .d_in({SYNC_I, CLK_I, OSC_STRAP}),
    .q_out(pins_s)
  );

  // Display memory; the read row follows the current slot.
  lmt_ram #(.COLS(LMT_COLS), .ROWS(LMT_ROWS)) u_ram (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .wr_en(RAM_WR_STB),
    .wr_col(RAM_WR_COL),
    .wr_data(RAM_WR_DATA),
    .rd_row(st_r.row),
    .rd_data(ram_rd)
  );

  // ----------------------------------------
  // Level helpers
  // ----------------------------------------

  // Slot length in timing ticks for a drive configuration.
  function automatic logic [4:0] slot_len(input lmt_mode_type m);
    logic [4:0] len;
    unique case (m)
      LMT_MODE_STATIC: len = LMT_SLOT_STATIC;
      LMT_MODE_MUX2: len = LMT_SLOT_MUX2;
      LMT_MODE_MUX3: len = LMT_SLOT_MUX3;
      LMT_MODE_MUX4: len = LMT_SLOT_MUX4;
    endcase
    return len;
  endfunction

  // Whether backplane k is selected in the current row slot.
  function automatic logic bp_sel(input int k, input logic [1:0] row, input lmt_mode_type m);
    logic sel;
    unique case (m)
      LMT_MODE_STATIC: sel = 1'b1;
      LMT_MODE_MUX2: sel = (2'(k) & 2'h1) == row;
      LMT_MODE_MUX3: sel = (k == 3) ? (row == 2'h1) : (2'(k) == row);
      LMT_MODE_MUX4: sel = 2'(k) == row;
    endcase
    return sel;
  endfunction

  // Backplane level: full swing when selected, mid levels otherwise.
  function automatic logic [1:0] bp_lvl(input logic sel, input logic pol, input logic third);
    logic [1:0] lvl;
    if (sel) begin
      lvl = pol ? LMT_LVL_VSS : LMT_LVL_VLCD;
    end else if (third) begin
      lvl = pol ? LMT_LVL_HIGH : LMT_LVL_LOW;
    end else begin
      lvl = LMT_LVL_LOW;
    end
    return lvl;
  endfunction

  // Element level: on opposes the selected backplane, off sits one bias step away, or at the backplane level in static mode.
  function automatic logic [1:0] seg_lvl(input logic on, input logic pol, input lmt_mode_type m,
                                         input logic third);
    logic [1:0] lvl;
    if (on) begin
      lvl = pol ? LMT_LVL_VLCD : LMT_LVL_VSS;
    end else if (m == LMT_MODE_STATIC) begin
      lvl = pol ? LMT_LVL_VSS : LMT_LVL_VLCD;
    end else if (third) begin
      lvl = pol ? LMT_LVL_LOW : LMT_LVL_HIGH;
    end else begin
      lvl = LMT_LVL_LOW;
    end
    return lvl;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  logic tick;
  logic restart;
  logic frame_end;
  logic slot_end;

  // Clock select, divider, slots, sync and output drive in one pass.
  always_comb begin
    st_nxt = st_r;
    tick = 1'b0;
    restart = 1'b0;
    frame_end = 1'b0;
    slot_end = 1'b0;
    st_nxt.frame = 1'b0;

    // Catch the strap once the synchroniser has settled after reset.
    if (!st_r.strap_done) begin
      st_nxt.strap_cnt = st_r.strap_cnt + 3'h1;
      if (st_r.strap_cnt == LMT_STRAP_WAIT) begin
        st_nxt.strap_done = 1'b1;
        st_nxt.ext_sel = pins_s[0];
      end
    end

    // Produce the timing tick from the selected source.
    if (st_r.strap_done && !st_r.ext_sel) begin
      if (st_r.osc_cnt == OSC_LAST) begin
        st_nxt.osc_cnt = '0;
        st_nxt.clk_o = ~st_r.clk_o;
        tick = ~st_r.clk_o;
      end else begin
        st_nxt.osc_cnt = st_r.osc_cnt + OW'(1);
      end
    end else if (st_r.strap_done) begin
      tick = pins_s[1] & ~st_r.clk_prev;
    end
    st_nxt.clk_prev = pins_s[1];

    // A fresh fall of the sync pin away from frame start means another driver restarted.
    // Only the edge counts: the own pull is still seen low for a few cycles after its release.
    restart = st_r.running && st_r.sync_prev && !pins_s[2] && (st_r.tick_cnt != 5'h0);
    st_nxt.sync_prev = pins_s[2];

    // Latch a mode-set command; it takes effect at the next frame start.
    if (MODE_SET_STB) begin
      st_nxt.mode_pend = lmt_mode_type'(MODE_SEL);
      st_nxt.bias_pend = BIAS_THIRD;
    end

    // Divide ticks into slots by the mode's slot length and the frame by a fixed count.
    if (restart) begin
      st_nxt.tick_cnt = 5'h0;
      st_nxt.sub_cnt = 5'h0;
      st_nxt.row = 2'h0;
      st_nxt.load_cnt = LMT_LOAD_DELAY;
    end else if (tick) begin
      st_nxt.running = 1'b1;
      frame_end = st_r.tick_cnt == (LMT_FRAME_DIV - 5'h1);
      slot_end = st_r.sub_cnt == (slot_len(st_r.mode) - 5'h1);
      st_nxt.tick_cnt = st_r.tick_cnt + 5'h1;
      st_nxt.sub_cnt = st_r.sub_cnt + 5'h1;
      if (!st_r.running || frame_end) begin
        st_nxt.tick_cnt = 5'h0;
        st_nxt.sub_cnt = 5'h0;
        st_nxt.row = 2'h0;
        st_nxt.pol = st_r.running ? ~st_r.pol : 1'b0;
        st_nxt.mode = st_r.mode_pend;
        st_nxt.bias_third = st_r.bias_pend;
        st_nxt.frame = 1'b1;
        st_nxt.load_cnt = LMT_LOAD_DELAY;
      end else if (slot_end) begin
        st_nxt.sub_cnt = 5'h0;
        st_nxt.row = st_r.row + 2'h1;
        st_nxt.load_cnt = LMT_LOAD_DELAY;
      end
    end

    // Pull sync low during the first tick of each frame.
    st_nxt.sync_oe_b = ~(st_nxt.running && (st_nxt.tick_cnt == 5'h0));

    // Drive the clock pin only once the strap has chosen the internal oscillator.
    st_nxt.clk_oe_b = ~(st_nxt.strap_done && !st_nxt.ext_sel);

    // After the memory read settles, load the display register and drive the outputs.
    if (st_r.load_cnt != 2'h0 && !(restart || tick)) begin
      st_nxt.load_cnt = st_r.load_cnt - 2'h1;
      if (st_r.load_cnt == 2'h1) begin
        st_nxt.disp = ram_rd;
        for (int k = 0; k < LMT_ROWS; k++) begin
          st_nxt.bp[2*k +: 2] = bp_lvl(bp_sel(k, st_r.row, st_r.mode), st_r.pol,
                                       st_r.bias_third && (st_r.mode != LMT_MODE_STATIC));
        end
        for (int n = 0; n < LMT_COLS; n++) begin
          st_nxt.seg[2*n +: 2] = seg_lvl(ram_rd[n], st_r.pol, st_r.mode,
                                         st_r.bias_third);
        end
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Reset leaves every drive output at the full LCD level and the default configuration.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= '0;
      st_r.mode <= LMT_MODE_RESET;
      st_r.mode_pend <= LMT_MODE_RESET;
      st_r.bias_third <= LMT_BIAS_THIRD_RESET;
      st_r.bias_pend <= LMT_BIAS_THIRD_RESET;
      st_r.bp <= {4{LMT_LVL_VLCD}};
      st_r.seg <= {LMT_COLS{LMT_LVL_VLCD}};
      st_r.sync_oe_b <= 1'b1;
      st_r.clk_oe_b <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Every output except SYNC_O, which is tied low, is a field of the state register.
  assign CLK_O = st_r.clk_o;
  assign CLK_OE_B = st_r.clk_oe_b;
  assign SYNC_O = 1'b0;
  assign SYNC_OE_B = st_r.sync_oe_b;
  assign BACKPLANE_DRIVE_OUTPUTS = st_r.bp;
  assign ELEMENT_DRIVE_OUTPUTS = st_r.seg;
  assign FRAME_RATE = st_r.frame;

endmodule

/* lmt_pkg.sv */
// Shared constants and types for the LCD multiplex drive timing block.
package lmt_pkg;

  // ----------------------------------------
  // Clock and frame timing
  // ----------------------------------------
  localparam int LMT_REF_FREQ_HZ = 20_000_000;
  localparam int LMT_OSC_FREQ_HZ = 1970;
  localparam int LMT_OSC_HALF_CYC = LMT_REF_FREQ_HZ / (2 * LMT_OSC_FREQ_HZ);
  localparam logic [4:0] LMT_FRAME_DIV = 5'h18;
  localparam logic [4:0] LMT_SLOT_STATIC = 5'h18;
  localparam logic [4:0] LMT_SLOT_MUX2 = 5'h0c;
  localparam logic [4:0] LMT_SLOT_MUX3 = 5'h08;
  localparam logic [4:0] LMT_SLOT_MUX4 = 5'h06;
  localparam logic [2:0] LMT_STRAP_WAIT = 3'h4;
  localparam logic [1:0] LMT_LOAD_DELAY = 2'h2;

  // ----------------------------------------
  // Display geometry
  // ----------------------------------------
  localparam int LMT_COLS = 60;
  localparam int LMT_ROWS = 4;

  // ----------------------------------------
  // Drive levels on the two-bit output codes
  // ----------------------------------------
  localparam logic [1:0] LMT_LVL_VSS = 2'h0;
  localparam logic [1:0] LMT_LVL_LOW = 2'h1;
  localparam logic [1:0] LMT_LVL_HIGH = 2'h2;
  localparam logic [1:0] LMT_LVL_VLCD = 2'h3;

  // ----------------------------------------
  // Drive configurations
  // ----------------------------------------
  typedef enum logic [1:0] {
    LMT_MODE_MUX4 = 2'b00,
    LMT_MODE_STATIC = 2'b01,
    LMT_MODE_MUX2 = 2'b10,
    LMT_MODE_MUX3 = 2'b11
  } lmt_mode_type;

  localparam lmt_mode_type LMT_MODE_RESET = LMT_MODE_MUX4;
  localparam logic LMT_BIAS_THIRD_RESET = 1'b0;

endpackage

/* lmt_sync3.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps
module lmt_sync3 #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous input and filtered result.
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } lmt_sync_type;

  lmt_sync_type st_r;
  lmt_sync_type st_nxt;

  // Shift the chain; the first stage feeds only the second.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  // Register the chain.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_out = st_r.q;

endmodule

/* lmt_ram.sv */
// Display memory of columns by rows with a per-column write and a registered row read.
`timescale 1ns/10ps
module lmt_ram #(
  parameter int COLS = 60,
  parameter int ROWS = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Column write port, one bit per row.
  input wire logic wr_en,
  input wire logic [5:0] wr_col,
  input wire logic [ROWS-1:0] wr_data,
  // Row read port.
  input wire logic [1:0] rd_row,
  output logic [COLS-1:0] rd_data
);

  logic [COLS-1:0] mem_r [ROWS];
  logic [COLS-1:0] rd_r;

  // Each row stores its bit of the written column.
  for (genvar k = 0; k < ROWS; k++) begin : g_row
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        mem_r[k] <= '0;
      end else if (wr_en && (int'(wr_col) < COLS)) begin
        mem_r[k][wr_col] <= wr_data[k];
      end
    end
  end

  // Read data come out of a register one cycle after the address.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_r <= '0;
    end else begin
      rd_r <= mem_r[rd_row];
    end
  end

  assign rd_data = rd_r;

endmodule

/* lmt_drive_monitor.sv */
// Concurrent checks on the ports of the LCD drive timing block.
`timescale 1ns/10ps
module lmt_drive_monitor
  import lmt_pkg::*;
#(
  parameter int OSC_HALF_CYC = LMT_OSC_HALF_CYC
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST_B,
  // Clock and sync pins.
  input wire logic OSC_STRAP,
  input wire logic CLK_O,
  input wire logic CLK_OE_B,
  input wire logic SYNC_I,
  input wire logic SYNC_O,
  input wire logic SYNC_OE_B,
  // Mode command.
  input wire logic MODE_SET_STB,
  input wire logic [1:0] MODE_SEL,
  // Drive outputs.
  input wire logic [7:0] BACKPLANE_DRIVE_OUTPUTS,
  input wire logic [119:0] ELEMENT_DRIVE_OUTPUTS,
  input wire logic FRAME_RATE
);
  localparam int FRAME_LAST = 48 * OSC_HALF_CYC - 1;
  lmt_mode_type pend_r;
  lmt_mode_type act_r;
  lmt_mode_type pend_q;
  logic [1:0] age_r;
  logic started_r;
  logic foreign_r;
  logic co_r;
  logic tog_r;
  logic [19:0] fc_r;
  logic [15:0] hc_r;
  logic [7:0] bp;
  logic ok_r;

  assign bp = BACKPLANE_DRIVE_OUTPUTS;
  assign ok_r = started_r && (age_r == 2'h3);

  // Tracks the applied mode, frame age, foreign sync pulls and clock half periods.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_r <= LMT_MODE_RESET;
      act_r <= LMT_MODE_RESET;
      pend_q <= LMT_MODE_RESET;
      age_r <= 2'h0;
      started_r <= 1'b0;
      foreign_r <= 1'b0;
      co_r <= 1'b0;
      tog_r <= 1'b0;
      fc_r <= 20'h0;
      hc_r <= 16'h0;
    end else begin
      if (MODE_SET_STB) begin
        pend_r <= lmt_mode_type'(MODE_SEL);
      end
      // The design applies the command pending one cycle before the marker rises.
      pend_q <= pend_r;
      if (FRAME_RATE) begin
        act_r <= pend_q;
        started_r <= 1'b1;
      end
      age_r <= FRAME_RATE ? 2'h0 : ((age_r == 2'h3) ? age_r : age_r + 2'h1);
      fc_r <= FRAME_RATE ? 20'h0 : fc_r + 20'h1;
      foreign_r <= foreign_r || (!SYNC_I && SYNC_OE_B);
      co_r <= CLK_O;
      tog_r <= tog_r || (CLK_O != co_r);
      hc_r <= (CLK_O != co_r) ? 16'h0 : hc_r + 16'h1;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  // A pull from another driver followed by the own restart pulse.
  sequence s_foreign_pull;
    started_r && SYNC_OE_B && $fell(SYNC_I);
  endsequence
  sequence s_own_pull;
    ##[1:6] !SYNC_OE_B;
  endsequence

  a_reset_drive_high: assert property ($rose(RST_B) |-> bp == 8'hff && &ELEMENT_DRIVE_OUTPUTS && !FRAME_RATE)
    else $error("drive levels not high after reset");
  a_static_bp_same: assert property (ok_r && act_r == LMT_MODE_STATIC |-> bp == {4{bp[1:0]}})
    else $error("static backplanes differ");
  a_mux2_bp_pairs: assert property (ok_r && act_r == LMT_MODE_MUX2 |-> bp[5:4] == bp[1:0] && bp[7:6] == bp[3:2])
    else $error("duplex backplane pairs differ");
  a_mux3_bp_copy: assert property (ok_r && act_r == LMT_MODE_MUX3 |-> bp[7:6] == bp[3:2])
    else $error("fourth backplane differs from second");
  a_mux4_bp_distinct: assert property (ok_r && act_r == LMT_MODE_MUX4 |-> bp != {4{bp[1:0]}})
    else $error("quad backplanes all alike");
  a_frame_period_exact: assert property (FRAME_RATE && started_r && !foreign_r && !CLK_OE_B |-> fc_r == FRAME_LAST)
    else $error("frame period wrong");
  a_frame_single_pulse: assert property (FRAME_RATE |=> !FRAME_RATE)
    else $error("frame marker longer than one cycle");
  a_frame_sync_pull: assert property (FRAME_RATE |-> !SYNC_OE_B)
    else $error("no sync pull at frame start");
  a_sync_restart_pull: assert property (s_foreign_pull |-> s_own_pull)
    else $error("no restart after foreign sync");
  a_osc_half_period: assert property ((CLK_O != co_r) && tog_r && !CLK_OE_B |-> hc_r == OSC_HALF_CYC - 1)
    else $error("clock pin half period wrong");
  a_strap_ext_input: assert property (OSC_STRAP |-> CLK_OE_B)
    else $error("clock pin driven with strap high");
  a_sync_open_drain: assert property (!SYNC_O)
    else $error("sync pin drives high");
endmodule

bind lmt_drive lmt_drive_monitor #(.OSC_HALF_CYC(OSC_HALF_CYC)) u_mon (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .OSC_STRAP(OSC_STRAP), .CLK_O(CLK_O), .CLK_OE_B(CLK_OE_B),
  .SYNC_I(SYNC_I), .SYNC_O(SYNC_O), .SYNC_OE_B(SYNC_OE_B), .MODE_SET_STB(MODE_SET_STB), .MODE_SEL(MODE_SEL),
  .BACKPLANE_DRIVE_OUTPUTS(BACKPLANE_DRIVE_OUTPUTS), .ELEMENT_DRIVE_OUTPUTS(ELEMENT_DRIVE_OUTPUTS),
  .FRAME_RATE(FRAME_RATE)
);

/* lmt_panel.sv */
// Panel model that records which rows of columns 0 and 59 saw the full on voltage.
`timescale 1ns/10ps
module lmt_panel (
  // Clock, reset and capture clear.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  // Drive level codes from the driver.
  input wire logic [7:0] bp,
  input wire logic [119:0] seg,
  // Rows seen on, per watched column.
  output logic [3:0] on0,
  output logic [3:0] on59
);
  // An element is on when backplane and segment sit at opposite rails.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      on0 <= 4'h0;
      on59 <= 4'h0;
    end else if (clear) begin
      on0 <= 4'h0;
      on59 <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (bp[2*k] == bp[2*k+1] && bp[2*k +: 2] == ~seg[1:0]) on0[k] <= 1'b1;
        if (bp[2*k] == bp[2*k+1] && bp[2*k +: 2] == ~seg[119:118]) on59[k] <= 1'b1;
      end
    end
  end
endmodule

/* lmt_drive_bench.sv */
// Self-checking bench of the LCD drive timing block with a panel model.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module lmt_drive_bench
  import lmt_pkg::*;
;
  logic clk = 0, rst_b = 0, strap = 0, ext_clk = 0, ext_en = 0, ext_sync_b = 1;
  logic mode_stb = 0, bias_third = 0, ram_stb = 0, panel_clr = 0;
  logic [1:0] mode_sel = 2'h0;
  logic [5:0] ram_col = 6'h0;
  logic [3:0] ram_data = 4'h0;
  wire clk_pin, clk_o, clk_oe_b, sync_pin, sync_o, sync_oe_b, frame;
  wire [7:0] bp;
  wire [119:0] seg;
  wire [3:0] on0, on59;
  int n_fail = 0;
  int n_compared = 0;
  lmt_mode_type md[4] = '{LMT_MODE_MUX4, LMT_MODE_MUX3, LMT_MODE_MUX2, LMT_MODE_STATIC};
  logic [7:0] eb[4] = '{8'h57, 8'h57, 8'h77, 8'hff};
  logic [3:0] e0[4] = '{4'h5, 4'h5, 4'h5, 4'hf};
  logic [3:0] e59[4] = '{4'ha, 4'ha, 4'ha, 4'h0};

  // Two-way clock pin and pulled-up sync wire.
  assign clk_pin = !clk_oe_b ? clk_o : ext_clk;
  assign sync_pin = (sync_oe_b ? 1'b1 : sync_o) & ext_sync_b;

  lmt_drive #(.OSC_HALF_CYC(4)) dut (.REF_CLK(clk), .RST_B(rst_b), .OSC_STRAP(strap), .CLK_I(clk_pin),
    .CLK_O(clk_o), .CLK_OE_B(clk_oe_b), .SYNC_I(sync_pin), .SYNC_O(sync_o), .SYNC_OE_B(sync_oe_b),
    .MODE_SET_STB(mode_stb), .MODE_SEL(mode_sel), .BIAS_THIRD(bias_third), .RAM_WR_STB(ram_stb),
    .RAM_WR_COL(ram_col), .RAM_WR_DATA(ram_data), .BACKPLANE_DRIVE_OUTPUTS(bp),
    .ELEMENT_DRIVE_OUTPUTS(seg), .FRAME_RATE(frame));
  lmt_panel u_panel (.clk(clk), .rst_b(rst_b), .clear(panel_clr), .bp(bp), .seg(seg), .on0(on0), .on59(on59));

  // System clock of 50 ns.
  initial begin
    forever #25 clk = ~clk;
  end

  // External timing clock, kept running whenever selected.
  initial begin
    forever begin
      repeat (10) @(posedge clk);
      #1 ext_clk = ext_en & ~ext_clk;
    end
  end

  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_frame(output int n);
    n = 0;
    do begin
      step(1);
      n++;
    end while (frame !== 1'b1 && n < 1000);
    if (n == 1000) begin
      n_fail++;
      wrap_up();
    end
  endtask

  task automatic do_reset(input logic s);
    rst_b = 0;
    strap = s;
    step(5);
    rst_b = 1;
  endtask

  task automatic ram_wr(input logic [5:0] c, input logic [3:0] d);
    ram_col = c;
    ram_data = d;
    ram_stb = 1;
    step(1);
    ram_stb = 0;
    step(1);
  endtask

  // Default mode, memory mapping and internal clock output.
  task automatic t_default();
    int n;
    int tg;
    logic prev;
    do_reset(1'b0);
    ram_wr(6'h00, 4'h5);
    ram_wr(6'h3b, 4'ha);
    ram_wr(6'h3c, 4'hf);
    wait_frame(n);
    step(4);
    `CHK("bp default", 8'h57, bp)
    `CHK("element 0", 2'h0, seg[1:0])
    `CHK("element 59", 2'h1, seg[119:118])
    `CHK("clk drive", 1'b0, clk_oe_b)
    tg = 0;
    prev = clk_o;
    repeat (64) begin
      step(1);
      if (clk_o !== prev) tg++;
      prev = clk_o;
    end
    `CHK("clk toggles", 16, tg)
  endtask

  // Every drive mode: backplane pattern, polarity, frame period, panel rows.
  task automatic t_modes();
    int n;
    logic [7:0] bp_a;
    for (int i = 0; i < 4; i++) begin
      mode_sel = md[i];
      bias_third = 1;
      mode_stb = 1;
      step(1);
      mode_stb = 0;
      wait_frame(n);
      wait_frame(n);
      step(4);
      bp_a = bp;
      `CHK("bp pattern", 1'b1, bp_a == eb[i] || bp_a == ~eb[i])
      panel_clr = 1;
      step(1);
      panel_clr = 0;
      wait_frame(n);
      `CHK("frame period", 192, 5 + n)
      step(4);
      `CHK("polarity", ~bp_a, bp)
      `CHK("rows col 0", e0[i], on0)
      `CHK("rows col 59", e59[i], on59)
    end
  endtask

  // A foreign pull mid-frame restarts the frame.
  task automatic t_sync();
    int n;
    int t;
    logic hit;
    wait_frame(n);
    step(50);
    ext_sync_b = 0;
    hit = 0;
    for (t = 1; t <= 8; t++) begin
      step(1);
      if (t == 4) ext_sync_b = 1;
      if (sync_oe_b === 1'b0) hit = 1;
    end
    `CHK("sync pull", 1'b1, hit)
    wait_frame(n);
    `CHK("restart", 1'b1, (n + 8) >= 185 && (n + 8) <= 210)
  endtask

  // External clock: pin stays an input and frame is 24 external periods.
  task automatic t_external();
    int n;
    ext_en = 1;
    do_reset(1'b1);
    wait_frame(n);
    `CHK("clk input", 1'b1, clk_oe_b)
    wait_frame(n);
    `CHK("ext period", 480, n)
  endtask

  // Main sequence.
  initial begin
    t_default();
    t_modes();
    t_sync();
    t_external();
    wrap_up();
  end

  // Watchdog against a hang.
  initial begin
    step(20000);
    n_fail++;
    wrap_up();
  end
endmodule
